//--- common/ssp_pkg.sv
package ssp_pkg;

   // core clock and instruction cycle timing
   localparam int CORE_CLK_NS = 4;
   localparam int INSTR_CYCLE_NS = 16;
   localparam int INSTR_CYCLE_CLKS = (INSTR_CYCLE_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

   // register bus geometry and byte offsets
   localparam int ADDR_W = 6;
   localparam logic [5:0] OFS_FLAGS = 6'h00;
   localparam logic [5:0] OFS_ENABLES = 6'h04;
   localparam logic [5:0] OFS_PRIORITIES = 6'h08;
   localparam logic [5:0] OFS_RCV_CTRL = 6'h0c;
   localparam logic [5:0] OFS_RCV_BUF = 6'h10;
   localparam logic [5:0] OFS_TX_CTRL = 6'h14;
   localparam logic [5:0] OFS_RATE = 6'h18;
   localparam logic [5:0] OFS_TX_BUF = 6'h1c;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // flag and enable bit positions
   localparam int FLAG_RX_BIT = 5;
   localparam int FLAG_TX_BIT = 4;

   // writable bit masks
   localparam logic [7:0] IRQ_BITS_MASK = 8'h30;
   localparam logic [7:0] TXC_WMASK = 8'hf5;
   localparam logic [7:0] RCV_WMASK = 8'hf8;

   // reset values
   localparam logic [7:0] TXC_RESET = 8'h00;
   localparam logic [7:0] RCV_RESET = 8'h00;
   localparam logic [7:0] IRQ_RESET = 8'h00;
   localparam logic [7:0] RATE_RESET = 8'h00;
   localparam logic [7:0] BUF_RESET = 8'h00;
   localparam logic TBE_RESET = 1'b1;

   typedef struct packed {
      logic clock_source_select;
      logic nine_bit_transmit;
      logic transmit_enable;
      logic sync_mode;
      logic unused3;
      logic high_rate_select;
      logic shifter_empty;
      logic transmit_ninth_bit;
   } tx_ctrl_t;

   typedef struct packed {
      logic port_enable;
      logic nine_bit_receive;
      logic single_receive_enable;
      logic continuous_receive_enable;
      logic address_detect_enable;
      logic framing_error;
      logic overrun_error;
      logic receive_ninth_bit;
   } rcv_ctrl_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_TX_LOAD,
      ST_TX_SHIFT,
      ST_RX_SHIFT
   } ssp_state_t;

endpackage

//--- hw/ssp_pin_sync.sv
`timescale 1ns/1ns
module ssp_pin_sync (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // pin level in, filtered level out
   input wire logic i_pin,
   output logic o_level
);
   logic stage1;
   logic stage2;
   logic stage3;
   logic next_level;

   // a change counts once the second and third stage agree
   always_comb begin
      next_level = o_level;
      if (stage2 == stage3) begin
         next_level = stage2;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
         o_level <= 1'b0;
      end else begin
         stage1 <= i_pin;
         stage2 <= stage1;
         stage3 <= stage2;
         o_level <= next_level;
      end
   end
endmodule

//--- hw/ssp_master.sv
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
//Contract
// RULE1: clock source select set makes the port a clock-sourcing master.
// RULE2: clocked-mode select set chooses synchronous operation.
// RULE3: half duplex: transmit blocks reception and reception blocks transmit.
// RULE4: port enable turns the two pins into shift clock and data lines.
// RULE5: master drives the shift clock for both directions.
// RULE6: shifter reloads from buffer only after last bit, at once if full.
// RULE7: buffer-to-shifter move takes one instruction cycle, then empty flag sets.
// RULE8: empty flag sets regardless of enable; only a buffer write clears it.
// RULE9: transmit interrupt raised only with transmit interrupt enable set.
// RULE10: shifter-empty bit is read-only status, drives no interrupt.
// RULE11: transmit shifter has no software address.
// RULE12: ninth transmit bit sent with each word when nine-bit transmit set.
// RULE13: with transmit enabled, a buffer write starts a transmission.
// RULE14: reception starts on single or continuous receive enable.
// RULE15: data line sampled on each falling edge of the generated clock.
// RULE16: single receive takes exactly one word, then stops.
// RULE17: continuous receive runs word after word until cleared; the code also stops it at an overrun error, until the enable is cleared.
// RULE18: both receive enables set behaves as continuous.
// RULE19: word done sets receive flag; interrupt only with its enable.
// RULE20: ninth bit and errors in receive status, data in receive buffer.
// RULE21: clearing continuous enable clears pending receive errors.
// RULE22: software clears both receive enables before setting one.
// RULE23: shift clock rate derives from rate divider and core clock.
// RULE24: words go least significant bit first, ninth bit last.
module ssp_master
   import ssp_pkg::*;
(
   // clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_RST_N,
   // axi4-lite write address and data
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [ADDR_W-1:0] I_AWADDR,
   input wire logic I_WVALID,
   output logic O_WREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   // axi4-lite write response
   output logic O_BVALID,
   input wire logic I_BREADY,
   output logic [1:0] O_BRESP,
   // axi4-lite read
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   input wire logic [ADDR_W-1:0] I_ARADDR,
   output logic O_RVALID,
   input wire logic I_RREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   // shift clock line
   output logic O_SHIFT_CLOCK_LINE,
   output logic O_SHIFT_CLOCK_LINE_OE_N,
   // shift data line
   input wire logic I_SHIFT_DATA_LINE,
   output logic O_SHIFT_DATA_LINE,
   output logic O_SHIFT_DATA_LINE_OE_N,
   // interrupt requests
   output logic O_TX_IRQ,
   output logic O_RX_IRQ
);
   // bus state
   logic aw_got, next_aw_got;
   logic w_got, next_w_got;
   logic [ADDR_W-1:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic w_lane0, next_w_lane0;
   logic bvalid, next_bvalid;
   logic [1:0] bresp, next_bresp;
   logic rvalid, next_rvalid;
   logic [31:0] rdata, next_rdata;
   logic [1:0] rresp, next_rresp;
   logic wr_fire;
   logic rd_fire;
   logic [ADDR_W-1:0] wr_ofs;
   logic [ADDR_W-1:0] rd_ofs;
   logic wr_hit;
   logic rd_rxbuf;
   logic wr_txbuf;
   // registers and engine state
   tx_ctrl_t txc, next_txc;
   rcv_ctrl_t rcv, next_rcv;
   logic [7:0] irq_en, next_irq_en;
   logic [7:0] irq_pri, next_irq_pri;
   logic [7:0] rate, next_rate;
   logic [7:0] tx_buf, next_tx_buf;
   logic tx_full, next_tx_full;
   logic tbe_flag, next_tbe_flag;
   logic [7:0] rx_buf, next_rx_buf;
   logic rcv_flag, next_rcv_flag;
   ssp_state_t st, next_st;
   logic [9:0] half_cnt, next_half_cnt;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [3:0] last_bit, next_last_bit;
   logic phase, next_phase;
   logic [2:0] ld_cnt, next_ld_cnt;
   logic [8:0] tx_sh, next_tx_sh;
   logic [8:0] rx_sh, next_rx_sh;
   logic clk_out, next_clk_out;
   logic din;
   logic mode_on;
   logic rx_req;
   logic [8:0] rate_p1;
   logic [9:0] half_len;
   logic rx_done;
   logic sample_now;
   logic [7:0] wbyte;

   ssp_pin_sync data_sync (
      .i_clk(I_CORE_CLK),
      .i_rst_n(I_RST_N),
      .i_pin(I_SHIFT_DATA_LINE),
      .o_level(din)
   );

   // bus handshakes
   assign O_AWREADY = !aw_got && !bvalid;
   assign O_WREADY = !w_got && !bvalid;
   assign O_ARREADY = !rvalid;
   assign O_BVALID = bvalid;
   assign O_BRESP = bresp;
   assign O_RVALID = rvalid;
   assign O_RDATA = rdata;
   assign O_RRESP = rresp;
   assign wr_fire = aw_got && w_got && !bvalid;
   assign rd_fire = I_ARVALID && !rvalid;
   assign wr_ofs = {aw_addr[ADDR_W-1:2], 2'b00};
   assign rd_ofs = {I_ARADDR[ADDR_W-1:2], 2'b00};
   assign wr_hit = wr_fire && w_lane0;
   assign wbyte = w_data[7:0];
   assign rd_rxbuf = rd_fire && (rd_ofs == OFS_RCV_BUF);
   assign wr_txbuf = wr_hit && (wr_ofs == OFS_TX_BUF);

   always_comb begin
      next_aw_got = aw_got;
      next_w_got = w_got;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_lane0 = w_lane0;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (I_AWVALID && O_AWREADY) begin
         next_aw_got = 1'b1;
         next_aw_addr = I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
         next_w_got = 1'b1;
         next_w_data = I_WDATA;
         next_w_lane0 = I_WSTRB[0];
      end
      if (wr_fire) begin
         next_aw_got = 1'b0;
         next_w_got = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = (aw_addr[ADDR_W-1] == 1'b0) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && I_BREADY) begin
         next_bvalid = 1'b0;
      end
      // the transmit shifter has no offset of its own
      if (rd_fire) begin //RULE11
         next_rvalid = 1'b1;
         next_rresp = RESP_OKAY;
         next_rdata = 32'h0;
         unique case (rd_ofs)
            OFS_FLAGS: begin
               next_rdata[FLAG_RX_BIT] = rcv_flag;
               next_rdata[FLAG_TX_BIT] = tbe_flag;
            end
            OFS_ENABLES: next_rdata[7:0] = irq_en;
            OFS_PRIORITIES: next_rdata[7:0] = irq_pri;
            OFS_RCV_CTRL: next_rdata[7:0] = rcv; //RULE20
            OFS_RCV_BUF: next_rdata[7:0] = rx_buf; //RULE20
            OFS_TX_CTRL: begin
               next_rdata[7:0] = txc;
               next_rdata[1] = (st != ST_TX_SHIFT); //RULE10
            end
            OFS_RATE: next_rdata[7:0] = rate;
            OFS_TX_BUF: next_rdata[7:0] = tx_buf;
            default: next_rresp = RESP_SLVERR;
         endcase
      end else if (rvalid && I_RREADY) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h0;
         w_lane0 <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= RESP_OKAY;
      end else begin
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_lane0 <= next_w_lane0;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   // master mode needs port enable, clocked mode and internal clock source
   assign mode_on = rcv.port_enable && txc.sync_mode && txc.clock_source_select; //RULE1 RULE2
   assign rx_req = rcv.single_receive_enable || rcv.continuous_receive_enable; //RULE14 RULE18
   // half bit lasts 2*(rate+1) core clocks
   assign rate_p1 = {1'b0, rate} + 9'h001; //RULE23
   assign half_len = {rate_p1, 1'b0}; //RULE23
   assign sample_now = (st == ST_RX_SHIFT) && (half_cnt == 10'h000) && !phase && mode_on && rx_req;
   assign rx_done = (st == ST_RX_SHIFT) && (half_cnt == 10'h000) && phase && mode_on && rx_req
      && (bit_cnt == last_bit);

   always_comb begin
      next_txc = txc;
      next_rcv = rcv;
      next_irq_en = irq_en;
      next_irq_pri = irq_pri;
      next_rate = rate;
      next_tx_buf = tx_buf;
      next_tx_full = tx_full;
      next_tbe_flag = tbe_flag;
      next_rx_buf = rx_buf;
      next_rcv_flag = rcv_flag;
      next_st = st;
      next_half_cnt = half_cnt;
      next_bit_cnt = bit_cnt;
      next_last_bit = last_bit;
      next_phase = phase;
      next_ld_cnt = ld_cnt;
      next_tx_sh = tx_sh;
      next_rx_sh = rx_sh;
      next_clk_out = clk_out;
      if (wr_hit) begin
         unique case (wr_ofs)
            OFS_ENABLES: next_irq_en = wbyte & IRQ_BITS_MASK;
            OFS_PRIORITIES: next_irq_pri = wbyte & IRQ_BITS_MASK;
            OFS_RATE: next_rate = wbyte;
            OFS_TX_CTRL: next_txc = tx_ctrl_t'((wbyte & TXC_WMASK) | (txc & ~TXC_WMASK));
            OFS_RCV_CTRL: begin
               next_rcv = rcv_ctrl_t'((wbyte & RCV_WMASK) | (rcv & ~RCV_WMASK));
               if (rcv.continuous_receive_enable && !next_rcv.continuous_receive_enable) begin
                  next_rcv.overrun_error = 1'b0; //RULE21
                  next_rcv.framing_error = 1'b0; //RULE21
               end
            end
            OFS_TX_BUF: begin
               next_tx_buf = wbyte;
               next_tx_full = 1'b1; //RULE13
               next_tbe_flag = 1'b0; //RULE8
            end
            default: ;
         endcase
      end
      if (rd_rxbuf) begin
         next_rcv_flag = 1'b0;
      end
      unique case (st)
         ST_IDLE: begin
            next_clk_out = 1'b0;
            // transmit has the line first; reception waits for an idle port
            if (mode_on && tx_full && txc.transmit_enable) begin //RULE3 RULE6 RULE13
               next_st = ST_TX_LOAD;
               next_ld_cnt = 3'(INSTR_CYCLE_CLKS - 1);
               // word taken at load start so a write during the load cannot replace it
               next_tx_sh = {txc.transmit_ninth_bit, tx_buf}; //RULE12 RULE24
               next_last_bit = txc.nine_bit_transmit ? 4'h8 : 4'h7; //RULE12
               next_tx_full = wr_txbuf;
            end else if (mode_on && rx_req && !rcv.overrun_error) begin //RULE14 RULE17
               next_st = ST_RX_SHIFT;
               next_bit_cnt = 4'h0;
               next_phase = 1'b0;
               next_half_cnt = half_len - 10'h001;
               next_last_bit = rcv.nine_bit_receive ? 4'h8 : 4'h7;
               next_clk_out = 1'b1; //RULE5
            end
         end
         ST_TX_LOAD: begin
            if (ld_cnt != 3'h0) begin
               next_ld_cnt = ld_cnt - 3'h1; //RULE7
            end else begin
               // a word written during the load keeps the buffer full
               next_tbe_flag = !(tx_full || wr_txbuf); //RULE7 RULE8
               next_st = ST_TX_SHIFT;
               next_bit_cnt = 4'h0;
               next_phase = 1'b0;
               next_half_cnt = half_len - 10'h001;
               next_clk_out = 1'b1; //RULE5
            end
         end
         ST_TX_SHIFT: begin
            if (half_cnt != 10'h000) begin
               next_half_cnt = half_cnt - 10'h001;
            end else begin
               next_half_cnt = half_len - 10'h001;
               next_phase = !phase;
               next_clk_out = phase;
               if (phase) begin
                  next_bit_cnt = bit_cnt + 4'h1;
                  next_tx_sh = {1'b0, tx_sh[8:1]}; //RULE24
                  if (bit_cnt == last_bit) begin //RULE6
                     next_clk_out = 1'b0;
                     next_st = ST_IDLE;
                     if (tx_full && txc.transmit_enable) begin //RULE6
                        next_st = ST_TX_LOAD;
                        next_ld_cnt = 3'(INSTR_CYCLE_CLKS - 1);
                        next_tx_sh = {txc.transmit_ninth_bit, tx_buf}; //RULE12 RULE24
                        next_last_bit = txc.nine_bit_transmit ? 4'h8 : 4'h7; //RULE12
                        next_tx_full = wr_txbuf;
                     end
                  end
               end
            end
         end
         ST_RX_SHIFT: begin
            if (half_cnt != 10'h000) begin
               next_half_cnt = half_cnt - 10'h001;
            end else begin
               next_half_cnt = half_len - 10'h001;
               next_phase = !phase;
               next_clk_out = phase;
               if (sample_now) begin
                  next_rx_sh[bit_cnt] = din; //RULE15
               end else if (rx_done) begin
                  next_st = ST_IDLE;
                  next_clk_out = 1'b0;
                  next_rcv.single_receive_enable = 1'b0; //RULE16
                  if (rcv_flag && !rd_rxbuf) begin
                     next_rcv.overrun_error = 1'b1; //RULE20
                  end else begin
                     next_rx_buf = rx_sh[7:0]; //RULE20
                     next_rcv.receive_ninth_bit = rcv.nine_bit_receive && rx_sh[8]; //RULE20
                     next_rcv_flag = 1'b1; //RULE19
                  end
               end else begin
                  next_bit_cnt = bit_cnt + 4'h1;
               end
            end
         end
      endcase
      // leaving master mode or dropping both receive enables stops the engine
      if (!mode_on || (st == ST_RX_SHIFT && !rx_req)) begin
         next_st = ST_IDLE;
         next_clk_out = 1'b0;
         // an aborted load still frees the buffer flag
         if (st == ST_TX_LOAD) begin
            next_tbe_flag = !(tx_full || wr_txbuf); //RULE7
         end
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         txc <= tx_ctrl_t'(TXC_RESET);
         rcv <= rcv_ctrl_t'(RCV_RESET);
         irq_en <= IRQ_RESET;
         irq_pri <= IRQ_RESET;
         rate <= RATE_RESET;
         tx_buf <= BUF_RESET;
         tx_full <= 1'b0;
         tbe_flag <= TBE_RESET;
         rx_buf <= BUF_RESET;
         rcv_flag <= 1'b0;
         st <= ST_IDLE;
         half_cnt <= 10'h000;
         bit_cnt <= 4'h0;
         last_bit <= 4'h7;
         phase <= 1'b0;
         ld_cnt <= 3'h0;
         tx_sh <= 9'h000;
         rx_sh <= 9'h000;
         clk_out <= 1'b0;
      end else begin
         txc <= next_txc;
         rcv <= next_rcv;
         irq_en <= next_irq_en;
         irq_pri <= next_irq_pri;
         rate <= next_rate;
         tx_buf <= next_tx_buf;
         tx_full <= next_tx_full;
         tbe_flag <= next_tbe_flag;
         rx_buf <= next_rx_buf;
         rcv_flag <= next_rcv_flag;
         st <= next_st;
         half_cnt <= next_half_cnt;
         bit_cnt <= next_bit_cnt;
         last_bit <= next_last_bit;
         phase <= next_phase;
         ld_cnt <= next_ld_cnt;
         tx_sh <= next_tx_sh;
         rx_sh <= next_rx_sh;
         clk_out <= next_clk_out;
      end
   end

   // pins: released unless the port runs as clocked master
   assign O_SHIFT_CLOCK_LINE = clk_out; //RULE5
   assign O_SHIFT_CLOCK_LINE_OE_N = !mode_on; //RULE4
   assign O_SHIFT_DATA_LINE = tx_sh[0];
   assign O_SHIFT_DATA_LINE_OE_N = !(mode_on && st == ST_TX_SHIFT); //RULE3 RULE4
   assign O_TX_IRQ = tbe_flag && irq_en[FLAG_TX_BIT]; //RULE9
   assign O_RX_IRQ = rcv_flag && irq_en[FLAG_RX_BIT]; //RULE19

   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_N);

   property p_master_needs_source;
      !txc.clock_source_select |-> O_SHIFT_CLOCK_LINE_OE_N && st == ST_IDLE;
   endproperty
   a_master_needs_source: assert property (p_master_needs_source) else $error("master active without clock source"); //RULE1

   property p_half_duplex;
      (st == ST_RX_SHIFT) |-> O_SHIFT_DATA_LINE_OE_N;
   endproperty
   a_half_duplex: assert property (p_half_duplex) else $error("data driven while receiving"); //RULE3

   property p_load_one_cycle;
      $rose(st == ST_TX_LOAD) |-> (st == ST_TX_LOAD)[*4] ##1 (st == ST_TX_SHIFT || !mode_on);
   endproperty
   a_load_one_cycle: assert property (p_load_one_cycle) else $error("load length wrong"); //RULE7

   property p_flag_after_load;
      (st == ST_TX_LOAD && ld_cnt == 3'h0 && mode_on && !wr_txbuf) |=> tbe_flag != tx_full;
   endproperty
   a_flag_after_load: assert property (p_flag_after_load) else $error("empty flag not set"); //RULE7

   property p_flag_write_only;
      $fell(tbe_flag) |-> $past(wr_txbuf);
   endproperty
   a_flag_write_only: assert property (p_flag_write_only) else $error("empty flag cleared"); //RULE8

   property p_tx_irq_gate;
      !irq_en[FLAG_TX_BIT] |-> !O_TX_IRQ;
   endproperty
   a_tx_irq_gate: assert property (p_tx_irq_gate) else $error("transmit irq unmasked"); //RULE9

   property p_reload;
      (st == ST_TX_SHIFT && mode_on) ##1 (st == ST_TX_LOAD) |-> $past(bit_cnt) == $past(last_bit);
   endproperty
   a_reload: assert property (p_reload) else $error("reload before last bit"); //RULE6

   property p_sample_fall;
      sample_now |=> !O_SHIFT_CLOCK_LINE && $past(O_SHIFT_CLOCK_LINE);
   endproperty
   a_sample_fall: assert property (p_sample_fall) else $error("sample not at falling edge"); //RULE15

   property p_single_stop;
      (rx_done && !rcv.continuous_receive_enable && !wr_hit) |=> (st != ST_RX_SHIFT) [*2];
   endproperty
   a_single_stop: assert property (p_single_stop) else $error("single receive went on"); //RULE16

   property p_done_flag;
      (rx_done && !rcv_flag) |=> rcv_flag ##0 rx_buf == $past(rx_sh[7:0]);
   endproperty
   a_done_flag: assert property (p_done_flag) else $error("receive flag not set"); //RULE19

   property p_err_clear;
      $fell(rcv.continuous_receive_enable) |-> !rcv.overrun_error && !rcv.framing_error;
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("error kept"); //RULE21

endmodule

//--- dv/ssp_peer.sv
`timescale 1ns/1ns
module ssp_peer (
   // shift clock and shared data line
   input wire logic i_clk_line,
   input wire logic i_line,
   // word to send and index restart
   input wire logic [8:0] i_word,
   input wire logic i_load,
   // data driven and bits seen
   output logic o_data,
   output logic [8:0] o_seen,
   output logic [7:0] o_falls
);
   int idx;
   assign o_data = i_word[idx];
   // follows the master clock only: next bit after each fall, lsb first
   always @(negedge i_clk_line or posedge i_load) begin
      if (i_load) begin
         idx <= 0;
         o_falls <= 8'h00;
      end else begin
         idx <= (idx == 8) ? 0 : idx + 1;
         o_falls <= o_falls + 8'h01;
         o_seen <= {i_line, o_seen[8:1]};
      end
   end
endmodule

//--- dv/tb_ssp_master.sv
`timescale 1ns/1ns
module tb_ssp_master;
   import ssp_pkg::*;
   logic clk, rst_n, awv, wv, bry, arv, rry, pload;
   logic [5:0] awa, ara;
   logic [31:0] wd, rdat;
   logic [1:0] br, rr;
   logic aw_r, w_r, bv, ar_r, rv, sck, sck_oe_n, dq_o, dq_oe_n, tx_irq, rx_irq, pd;
   logic [8:0] seen;
   logic [7:0] falls;
   int err_total = 0;
   int samples_checked = 0;
   wire line = dq_oe_n ? pd : dq_o;
   ssp_master i_ssp_master (
      .I_CORE_CLK(clk), .I_RST_N(rst_n),
      .I_AWVALID(awv), .O_AWREADY(aw_r), .I_AWADDR(awa),
      .I_WVALID(wv), .O_WREADY(w_r), .I_WDATA(wd), .I_WSTRB(4'h1),
      .O_BVALID(bv), .I_BREADY(bry), .O_BRESP(br),
      .I_ARVALID(arv), .O_ARREADY(ar_r), .I_ARADDR(ara),
      .O_RVALID(rv), .I_RREADY(rry), .O_RDATA(rdat), .O_RRESP(rr),
      .O_SHIFT_CLOCK_LINE(sck), .O_SHIFT_CLOCK_LINE_OE_N(sck_oe_n),
      .I_SHIFT_DATA_LINE(line), .O_SHIFT_DATA_LINE(dq_o),
      .O_SHIFT_DATA_LINE_OE_N(dq_oe_n), .O_TX_IRQ(tx_irq), .O_RX_IRQ(rx_irq)
   );
   ssp_peer i_ssp_peer (
      .i_clk_line(sck), .i_line(line), .i_word(9'h15a), .i_load(pload),
      .o_data(pd), .o_seen(seen), .o_falls(falls)
   );
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic test_done();
      $display("checked %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic tmo();
      err_total++;
      test_done();
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= {24'h0, d};
      bry <= 1'b1;
      do begin
         @(posedge clk);
         if (aw_r === 1'b1) awv <= 1'b0;
         if (w_r === 1'b1) wv <= 1'b0;
         n++;
      end while (bv !== 1'b1 && n < 50);
      bry <= 1'b0;
      if (bv !== 1'b1) tmo();
      chk(br, (a >= 6'h20) ? RESP_SLVERR : RESP_OKAY);
   endtask
   task automatic xr(input logic [5:0] a, output logic [7:0] v, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      arv <= 1'b1;
      ara <= a;
      rry <= 1'b1;
      do begin
         @(posedge clk);
         if (ar_r === 1'b1) arv <= 1'b0;
         n++;
      end while (rv !== 1'b1 && n < 50);
      v = rdat[7:0];
      r = rr;
      rry <= 1'b0;
      if (rv !== 1'b1) tmo();
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
      logic [7:0] v;
      logic [1:0] r;
      xr(a, v, r);
      chk(v & m, e);
      chk(r, (a >= 6'h20) ? RESP_SLVERR : RESP_OKAY);
   endtask
   task automatic wt(input logic [5:0] a, input logic [7:0] m);
      logic [7:0] v;
      logic [1:0] r;
      for (int i = 0; i < 300; i++) begin
         xr(a, v, r);
         if ((v & m) != 8'h00) return;
      end
      tmo();
   endtask
   initial begin
      rst_n = 1'b0;
      awv = 1'b0;
      wv = 1'b0;
      bry = 1'b0;
      arv = 1'b0;
      rry = 1'b0;
      awa = 6'h00;
      ara = 6'h00;
      wd = 32'h0;
      pload = 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      pload <= 1'b1;
      rd(OFS_FLAGS, 8'h10);
      rd(OFS_TX_CTRL, 8'h02);
      rd(6'h20, 8'h00);
      wr(6'h20, 8'h55);
      wr(OFS_RATE, 8'h02);
      wr(OFS_RCV_CTRL, 8'h80);
      wr(OFS_TX_CTRL, 8'hf1);
      chk(sck_oe_n, 1'b0);
      rd(OFS_TX_CTRL, 8'hf3);
      pload <= 1'b0;
      wr(OFS_TX_BUF, 8'ha5);
      wr(OFS_TX_BUF, 8'h3c);
      rd(OFS_FLAGS, 8'h00);
      wt(OFS_FLAGS, 8'h10);
      chk(tx_irq, 1'b0);
      wt(OFS_TX_CTRL, 8'h02);
      chk(seen, 9'h13c);
      chk(falls, 8'd18);
      wr(OFS_FLAGS, 8'h00);
      rd(OFS_FLAGS, 8'h10);
      wr(OFS_ENABLES, 8'h30);
      chk(tx_irq, 1'b1);
      pload <= 1'b1;
      wr(OFS_RCV_CTRL, 8'he0);
      pload <= 1'b0;
      chk(dq_oe_n, 1'b1);
      wt(OFS_FLAGS, 8'h20);
      chk(rx_irq, 1'b1);
      rd(OFS_RCV_CTRL, 8'hc1);
      rd(OFS_RCV_BUF, 8'h5a);
      rd(OFS_FLAGS, 8'h10);
      pload <= 1'b1;
      wr(OFS_RCV_CTRL, 8'hf0);
      pload <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         wt(OFS_FLAGS, 8'h20);
         rd(OFS_RCV_BUF, 8'h5a);
      end
      wt(OFS_RCV_CTRL, 8'h02);
      wr(OFS_RCV_CTRL, 8'hc0);
      rd(OFS_RCV_CTRL, 8'h00, 8'h32);
      test_done();
   end
endmodule
